// [hw/image_sensor_control_pins.v]
// sensor digital control: parameter upload, sequencer, converter pipeline
// Contract
// (RULE1) on register load clock rising edge, parameter bus goes into addressed register
// (RULE2) pixel rate set by pixel-rate clock; one pixel per clock cycle (code steps one pixel per converter sample tick instead)
// (RULE3) active-high global reset clears whole internal state
// (RULE4) global reset returns every configuration register to all zero
// (RULE5) controller should run clock and pulse reset after power-up
// (RULE6) column shift registers defined only after first column sync
// (RULE7) end-of-line pulse at each line close; usable as line-advance
// (RULE8) end-of-frame pulse at each frame close; usable as frame-begin
// (RULE9) pixel-valid high exactly while pixel data is read out
// (RULE10) pixel word is 10 bits, bit 9 most significant
// (RULE11) unused debug scan inputs held low, observe output left floating
// (RULE12) internal converter clock is half pixel clock, sampling on falling edge
// (RULE13) converter latency is two converter clock cycles
// (RULE14) parameter words 16 bits, rising shift clock, address first, msb first
// (RULE15) controller resets before upload and keeps pulses synchronous
`include "sensor_pins_defs.vh"
module image_sensor_control_pins
#(
    parameter LINE_W  = 12,
    parameter DELAY_W = 12
)
(
    // clocking
    input  wire                 clk,
    input  wire                 ce,
    input  wire                 reset,
    // parameter upload pins
    input  wire                 param_shift_clock,
    input  wire                 param_shift_data,
    input  wire                 register_load_clock,
    // readout control pins
    input  wire                 line_advance_in,
    input  wire                 frame_begin_in,
    input  wire                 converter_clock_in,
    // debug scan pins
    input  wire                 debug_scan_reset,
    input  wire                 debug_scan_clock,
    input  wire                 debug_scan_serial_in,
    output reg                  debug_scan_observe_out,
    // analog front end sample in
    input  wire [`PIX_W-1:0]    analog_sample,
    // readout outputs
    output reg  [`PIX_W-1:0]    pixel_data,
    output reg                  line_end_flag,
    output reg                  frame_end_flag,
    output reg                  pixel_window_valid,
    output reg                  column_sync_done
);
    // pins are asynchronous to clk, so each is synchronised first
    wire s_sclk, s_sdat, s_load, s_line, s_frame, s_cclk, s_bsr, s_bsc, s_bsd;
    sync2 u_sclk  (.clk(clk), .ce(ce), .reset(reset), .pin(param_shift_clock),
                   .sync_out(s_sclk));
    sync2 u_sdat  (.clk(clk), .ce(ce), .reset(reset), .pin(param_shift_data),
                   .sync_out(s_sdat));
    sync2 u_load  (.clk(clk), .ce(ce), .reset(reset), .pin(register_load_clock),
                   .sync_out(s_load));
    sync2 u_line  (.clk(clk), .ce(ce), .reset(reset), .pin(line_advance_in),
                   .sync_out(s_line));
    sync2 u_frame (.clk(clk), .ce(ce), .reset(reset), .pin(frame_begin_in),
                   .sync_out(s_frame));
    sync2 u_cclk  (.clk(clk), .ce(ce), .reset(reset), .pin(converter_clock_in),
                   .sync_out(s_cclk));
    sync2 u_bsr   (.clk(clk), .ce(ce), .reset(reset), .pin(debug_scan_reset),
                   .sync_out(s_bsr));
    sync2 u_bsc   (.clk(clk), .ce(ce), .reset(reset), .pin(debug_scan_clock),
                   .sync_out(s_bsc));
    sync2 u_bsd   (.clk(clk), .ce(ce), .reset(reset), .pin(debug_scan_serial_in),
                   .sync_out(s_bsd));

    // edge detectors read only the second synchroniser stage
    reg p_sclk, p_load, p_line, p_frame, p_cclk, p_bsc;
    wire sclk_rise  = s_sclk & ~p_sclk;
    wire load_rise  = s_load & ~p_load;
    wire line_rise  = s_line & ~p_line;
    wire frame_rise = s_frame & ~p_frame;
    wire cclk_fall  = ~s_cclk & p_cclk;
    wire bsc_rise   = s_bsc & ~p_bsc;

    // parameter shifter and register file
    reg [`PARAM_WORD_W-1:0] shifter;
    reg [`PARAM_DATA_W-1:0] cfg [0:`PARAM_REGS-1];
    integer i;

    // sequencer state
    localparam ST_IDLE = 2'b00;
    localparam ST_SYNC = 2'b01;
    localparam ST_READ = 2'b10;
    localparam ST_WAIT = 2'b11;
    reg [1:0]        state;
    reg [LINE_W-1:0] col;
    reg [LINE_W-1:0] row;
    reg [DELAY_W-1:0] delay_cnt;

    // converter clock and pipeline
    reg              half_clk;
    reg [`PIX_W-1:0] pipe [0:`CONV_LATENCY-1];
    reg [`CONV_LATENCY-1:0] valid_pipe;
    reg [`CONV_LATENCY-1:0] last_pipe;
    reg [`CONV_LATENCY-1:0] flast_pipe;
    reg [`PARAM_WORD_W-1:0] scan_chain;

    wire ext_sel = cfg[`ADDR_CONV_SEL][0];
    // internal clock toggles every pixel clock, so it falls every second one
    wire sample  = ext_sel ? cclk_fall : half_clk; // see (RULE12)
    wire line_last  = (col == cfg[`ADDR_LINE_LEN][LINE_W-1:0]);
    wire frame_last = (row == cfg[`ADDR_LINE_COUNT][LINE_W-1:0]);
    wire reading    = (state == ST_READ);

    always @(posedge clk)
    begin
        if (reset) // see (RULE3)
        begin
            p_sclk <= 1'b0;
            p_load <= 1'b0;
            p_line <= 1'b0;
            p_frame <= 1'b0;
            p_cclk <= 1'b0;
            p_bsc <= 1'b0;
            shifter <= 16'h0000;
            for (i = 0; i < `PARAM_REGS; i = i + 1)
                cfg[i] <= `CFG_RESET_VAL; // see (RULE4)
            state <= ST_IDLE;
            col <= {LINE_W{1'b0}};
            row <= {LINE_W{1'b0}};
            delay_cnt <= {DELAY_W{1'b0}};
            half_clk <= 1'b0;
            pipe[0] <= 10'h000;
            pipe[1] <= 10'h000;
            valid_pipe <= 2'h0;
            last_pipe <= 2'h0;
            flast_pipe <= 2'h0;
            scan_chain <= 16'h0000;
            pixel_data <= 10'h000;
            line_end_flag <= 1'b0;
            frame_end_flag <= 1'b0;
            pixel_window_valid <= 1'b0;
            column_sync_done <= 1'b0;
            debug_scan_observe_out <= 1'b0;
        end
        else if (ce)
        begin
            p_sclk <= s_sclk;
            p_load <= s_load;
            p_line <= s_line;
            p_frame <= s_frame;
            p_cclk <= s_cclk;
            p_bsc <= s_bsc;
            if (sclk_rise)
                shifter <= {shifter[`PARAM_WORD_W-2:0], s_sdat}; // see (RULE14)
            if (load_rise) // see (RULE1)
                cfg[shifter[`PARAM_WORD_W-1:`PARAM_DATA_W]] <=
                    shifter[`PARAM_DATA_W-1:0];
            half_clk <= ~half_clk;
            line_end_flag <= 1'b0;
            frame_end_flag <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (frame_rise)
                    begin
                        row <= {LINE_W{1'b0}};
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (line_rise)
                    begin
                        delay_cnt <= {DELAY_W{1'b0}};
                        state <= ST_SYNC;
                    end
                    else if (frame_rise)
                        row <= {LINE_W{1'b0}};
                end
                ST_SYNC:
                begin
                    // column sync lags the line pulse by a programmed delay
                    delay_cnt <= delay_cnt + 1'b1;
                    if (delay_cnt >= cfg[`ADDR_SYNC_DELAY][DELAY_W-1:0])
                    begin
                        column_sync_done <= 1'b1; // see (RULE6)
                        col <= {LINE_W{1'b0}};
                        state <= ST_READ;
                    end
                end
                ST_READ:
                begin
                    // one converter serves every column, so columns step on sample ticks;
                    // a tick that skipped a column would also lose its line end
                    if (sample)
                    begin
                        col <= col + 1'b1; // see (RULE2)
                        if (line_last)
                        begin
                            row <= row + 1'b1;
                            state <= frame_last ? ST_IDLE : ST_WAIT;
                        end
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
            // converter pipeline: data lags sampling by two sample clocks
            if (sample) // see (RULE13)
            begin
                pipe[0] <= analog_sample;
                pipe[1] <= pipe[0];
                valid_pipe <= {valid_pipe[0], reading};
                last_pipe <= {last_pipe[0], reading & line_last};
                flast_pipe <= {flast_pipe[0], reading & line_last & frame_last};
                pixel_data <= pipe[1]; // see (RULE10)
                pixel_window_valid <= valid_pipe[1]; // see (RULE9)
                line_end_flag <= last_pipe[1]; // see (RULE7)
                frame_end_flag <= flast_pipe[1]; // see (RULE8)
            end
            // debug scan chain shifts the serial scan input; floating when unused is host's concern
            if (s_bsr)
                scan_chain <= 16'h0000;
            else if (bsc_rise)
                scan_chain <= {scan_chain[`PARAM_WORD_W-2:0], s_bsd};
            debug_scan_observe_out <= scan_chain[`PARAM_WORD_W-1];
        end
    end
endmodule

// [include/sensor_pins_defs.vh]
// constants for the sensor pin-level control and readout block
`ifndef SENSOR_PINS_DEFS_VH
`define SENSOR_PINS_DEFS_VH
`define PIX_W            10
`define PARAM_WORD_W     16
`define PARAM_ADDR_W     4
`define PARAM_DATA_W     12
`define PARAM_REGS       16
`define CFG_RESET_VAL    12'h000
`define CONV_LATENCY     2
`define ADDR_LINE_LEN    4'h0
`define ADDR_LINE_COUNT  4'h1
`define ADDR_SYNC_DELAY  4'h2
`define ADDR_CONV_SEL    4'h3
`define DFLT_LINE_LEN    12'h010
`define DFLT_LINE_COUNT  12'h008
`define DFLT_SYNC_DELAY  12'h028
`endif

// [hw/sync2.v]
// two-flop synchroniser for one pin
module sync2
(
    input  wire clk,
    input  wire ce,
    input  wire reset,
    input  wire pin,
    output reg  sync_out
);
    reg stage1;
    always @(posedge clk)
    begin
        if (reset)
        begin
            stage1   <= 1'b0;
            sync_out <= 1'b0;
        end
        else if (ce)
        begin
            stage1   <= pin;
            sync_out <= stage1;
        end
    end
endmodule

// [sim/sensor_pins_assertions.sv]
// assertion checker for the sensor readout pins
`include "sensor_pins_defs.vh"
module sensor_pins_assertions
(
    // clocking
    input wire              clk,
    input wire              ce,
    input wire              reset,
    // readout outputs
    input wire [`PIX_W-1:0] pixel_data,
    input wire              line_end_flag,
    input wire              frame_end_flag,
    input wire              pixel_window_valid,
    input wire              column_sync_done
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // a flag must be cleared again within one to three clocks after it rises
    sequence s_drop(sig);
        ##[1:3] !sig;
    endsequence
    AST_RESET_CLEAR: assert property ($fell(reset) |-> !pixel_window_valid && !line_end_flag
        && !frame_end_flag && !column_sync_done && pixel_data == 0) else $error("outputs not clear");
    AST_SYNC_STICKY: assert property (column_sync_done |=> column_sync_done)
        else $error("column sync lost");
    AST_VALID_AFTER_SYNC: assert property (pixel_window_valid |-> column_sync_done)
        else $error("pixels before column sync");
    AST_LINE_PULSE: assert property ($rose(line_end_flag) |-> s_drop(line_end_flag))
        else $error("line end too long");
    AST_FRAME_PULSE: assert property ($rose(frame_end_flag) |-> s_drop(frame_end_flag))
        else $error("frame end too long");
    AST_FRAME_ON_LINE: assert property (frame_end_flag |-> line_end_flag)
        else $error("frame end off a line end");
    AST_END_IN_WINDOW: assert property ($rose(line_end_flag) |-> pixel_window_valid)
        else $error("line end outside window");
    // pixel data moves on converter ticks only, so a new word holds at least two clocks
    AST_TICK_HOLD: assert property ($changed(pixel_data) |=> $stable(pixel_data))
        else $error("pixel word held one clock");
endmodule
bind image_sensor_control_pins sensor_pins_assertions chk (.clk(clk), .ce(ce), .reset(reset),
    .pixel_data(pixel_data), .line_end_flag(line_end_flag), .frame_end_flag(frame_end_flag),
    .pixel_window_valid(pixel_window_valid), .column_sync_done(column_sync_done));

// [sim/camera_ctrl_model.sv]
// camera controller model: parameter upload and frame pulses
module camera_ctrl_model
(
    // clock and feedback
    input  wire  clk,
    input  wire  line_end_flag,
    input  wire  frame_end_flag,
    // pins into the sensor
    output logic param_shift_clock = 1'b0,
    output logic param_shift_data = 1'b0,
    output logic register_load_clock = 1'b0,
    output logic frame_begin_in = 1'b0,
    output wire  line_advance_in,
    output wire  scan_low
);
    timeunit 1ns;
    timeprecision 1ns;
    logic manual_line = 1'b0;
    assign scan_low = 1'b0;
    // line end fed back as next line advance, but not past the frame end
    assign line_advance_in = manual_line | (line_end_flag & !frame_end_flag);
    // pins pass synchronisers, so every level stands four clocks
    task automatic hold();
        repeat (4) @(posedge clk);
        #10;
    endtask
    task automatic upload(input logic [15:0] word);
        for (int i = 15; i >= 0; i--)
        begin
            param_shift_data = word[i];
            hold();
            param_shift_clock = 1'b1;
            hold();
            param_shift_clock = 1'b0;
        end
        register_load_clock = 1'b1;
        hold();
        register_load_clock = 1'b0;
        hold();
    endtask
    task automatic start_frame();
        frame_begin_in = 1'b1;
        hold();
        frame_begin_in = 1'b0;
        hold();
        manual_line = 1'b1;
        hold();
        manual_line = 1'b0;
    endtask
endmodule

// [sim/testbench.sv]
// self-checking bench for the sensor control and readout pins
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic [9:0] analog_sample = 10'h000;
    logic       ce = 1'b1;
    logic       conv_clk = 1'b0;
    logic       conv_run = 1'b0;
    wire        scan_obs;
    wire        psc, psd, rlc, lai, fbi, low;
    wire  [9:0] pixel_data;
    wire        line_end_flag, frame_end_flag, pixel_window_valid, column_sync_done;
    int         bad_count = 0;
    int         checks = 0;
    int         len;
    int         cnt;
    initial forever #50 clk = ~clk;
    // external converter clock: once enabled it falls every fourth pixel clock
    initial forever
    begin
        repeat (2) @(posedge clk);
        #10;
        if (conv_run)
            conv_clk = ~conv_clk;
    end
    image_sensor_control_pins DUT (.clk(clk), .ce(ce), .reset(reset), .param_shift_clock(psc),
        .param_shift_data(psd), .register_load_clock(rlc), .line_advance_in(lai),
        .frame_begin_in(fbi), .converter_clock_in(conv_clk), .debug_scan_reset(low),
        .debug_scan_clock(low), .debug_scan_serial_in(low), .debug_scan_observe_out(scan_obs),
        .analog_sample(analog_sample), .pixel_data(pixel_data), .line_end_flag(line_end_flag),
        .frame_end_flag(frame_end_flag), .pixel_window_valid(pixel_window_valid),
        .column_sync_done(column_sync_done));
    camera_ctrl_model ctl (.clk(clk), .line_end_flag(line_end_flag),
        .frame_end_flag(frame_end_flag), .param_shift_clock(psc), .param_shift_data(psd),
        .register_load_clock(rlc), .frame_begin_in(fbi), .line_advance_in(lai), .scan_low(low));
    // each pixel stands one converter tick of two clocks
    function automatic int exp_valid(input int l, input int c);
        return 2 * (l + 1) * (c + 1);
    endfunction
    task automatic print_verdict();
        if (bad_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic run_frame(input int lines, input int vcyc);
        int nv, nl, bad_pix, tail, n;
        logic prev;
        nv = 0; nl = 0; bad_pix = 0; tail = -1; n = 0; prev = 1'b0;
        analog_sample = 10'($urandom);
        fork
            ctl.start_frame();
        join_none
        while (tail != 0 && n < 3000)
        begin
            @(posedge clk);
            #10;
            n++;
            nv += (pixel_window_valid === 1'b1);
            nl += (line_end_flag === 1'b1 && !prev);
            prev = line_end_flag;
            bad_pix += (pixel_window_valid === 1'b1 && pixel_data !== analog_sample);
            if (tail < 0 && frame_end_flag === 1'b1)
                tail = 10;
            else if (tail > 0)
                tail--;
        end
        `CHK(tail, 0)
        `CHK(nl, lines)
        `CHK(nv, vcyc)
        `CHK(bad_pix, 0)
    endtask
    initial
    begin
        #5000000;
        bad_count++;
        print_verdict();
    end
    initial
    begin
        void'($urandom(32'hB2F0));
        repeat (2) @(posedge clk);
        #10;
        reset = 1'b0;
        `CHK(column_sync_done, 1'b0)
        run_frame(1, exp_valid(0, 0));
        `CHK(column_sync_done, 1'b1)
        for (int k = 0; k < 4; k++)
        begin
            len = (k == 3) ? 7 : $urandom % 8;
            cnt = (k == 3) ? 2 : $urandom % 3;
            ctl.upload({4'h0, 12'(len)});
            ctl.upload({4'h1, 12'(cnt)});
            ctl.upload({4'h2, 12'($urandom % 4)});
            run_frame(cnt + 1, exp_valid(len, cnt));
        end
        // external converter clock ticks every four clocks, so each pixel stands twice as long
        conv_run = 1'b1;
        ctl.upload({4'h3, 12'h001});
        run_frame(cnt + 1, 2 * exp_valid(len, cnt));
        `CHK(scan_obs, 1'b0)
        // a second reset must drop the loaded line shape and clock select back to zero
        reset = 1'b1;
        repeat (2) @(posedge clk);
        #10;
        reset = 1'b0;
        `CHK(column_sync_done, 1'b0)
        // pin pulses while the enable is low must leave the sequencer untouched
        ce = 1'b0;
        ctl.start_frame();
        repeat (8) @(posedge clk);
        #10;
        ce = 1'b1;
        repeat (8) @(posedge clk);
        #10;
        `CHK(column_sync_done, 1'b0)
        `CHK(pixel_window_valid, 1'b0)
        run_frame(1, exp_valid(0, 0));
        print_verdict();
    end
endmodule
